// ---- sdram_cmd_burst.sv ----
`timescale 1ns/1ps
// Behaviour
// - Length two: column bits 9..1 pick the block, bit 0 the start.
// - Length four: column bits 9..2 pick the block, bits 1..0 the start.
// - Length eight: column bits 9..3 pick the block, bits 2..0 the start.
// - A burst wraps inside its own column block.
// - Full page covers 1,024 columns, sequential only, wrapping in the row.
// - Length one accesses exactly the given column; burst type ignored.
// - One mode bit selects sequential or interleaved order.
// - Sequential adds access count modulo length; interleaved XORs it.
// - Read latency is two or three clocks; controller uses only those.
// - Read at edge n, latency m: drive from n+m-1, valid by n+m.
// - Write burst mode bit set makes every write a single access.
// - Clock enable high except self refresh; chip select high inhibits.
// - Activate opens the addressed row in the selected bank.
// - Read starts a burst at column bits 9..0 of the selected bank.
// - Write takes data with the command and bursts from the column.
// - Address bit 10 on read or write requests auto precharge.
// - Precharge closes one bank, or all banks when bit 10 is high.
// - Refresh code is auto refresh with clock enable high, else self.
// - Refresh uses the internal row counter; other inputs ignored.
// - Load mode takes address bits 11..0 as the new mode.
// - Byte mask blocks writes at once, disables reads two clocks later.
// - Mode fields: length, type, latency, operating mode, write burst.

// Write buffer between the pins and the array
module wr_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem_q[rp_q];

  // Storage
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_q[wp_q] <= in_data_i;
    end
  end

  // Pointers and fill level
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module sdram_cmd_burst #(
  parameter int unsigned DQ_W     = 64,
  parameter int unsigned ROW_KEEP = 1,
  parameter int unsigned WB_DEPTH = 32
) (
  input  wire logic                     core_clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     cke_i,
  input  wire sdram_pkg::cmd_pins_t     cmd_i,
  input  wire logic                     bank_select_0_i,
  input  wire logic                     bank_select_1_i,
  input  wire logic [12:0]              addr_i,
  input  wire logic [DQ_W/8-1:0]        byte_mask_i,
  input  wire logic [DQ_W-1:0]          dq_i,
  output logic      [DQ_W-1:0]          dq_o,
  output logic      [DQ_W/8-1:0]        dq_oe_o,
  output sdram_pkg::mode_t              mode_o,
  output logic      [3:0]               bank_open_o,
  output logic                          self_refresh_o,
  output logic      [12:0]              refresh_row_o,
  output logic                          wbuf_ready_o
);
  localparam int unsigned NB  = DQ_W / 8;
  localparam int unsigned IW  = 2 + ROW_KEEP + sdram_pkg::COL_W;
  localparam int unsigned EW  = IW + NB + DQ_W;

  sdram_pkg::cmd_t  cmd;
  sdram_pkg::mode_t mode_q;
  logic [1:0]       bank;
  logic [3:0]       bank_open_q;
  logic [12:0]      open_row_q [4];
  logic             sref_q;
  logic [12:0]      ref_cnt_q;
  logic             bact_q;
  logic             bwr_q;
  logic             bap_q;
  logic             binter_q;
  logic [1:0]       bbank_q;
  logic [9:0]       bstart_q;
  logic [9:0]       bmask_q;
  logic [9:0]       bk_q;
  logic [9:0]       blast_q;
  logic [9:0]       new_mask;
  logic [9:0]       new_last;
  logic [9:0]       cur_col;
  logic             acc_v;
  logic             acc_wr;
  logic             acc_ap;
  logic             acc_end;
  logic [1:0]       acc_bank;
  logic [9:0]       acc_col;
  logic [IW-1:0]    acc_idx;
  logic [DQ_W-1:0]  arr_q [2**IW];
  logic             rd0_v_q;
  logic             rd1_v_q;
  logic [DQ_W-1:0]  rd0_q;
  logic [DQ_W-1:0]  rd1_q;
  logic             rd2_v_q;
  logic [DQ_W-1:0]  rd2_q;
  logic [NB-1:0]    m1_q;
  logic [NB-1:0]    m2_q;
  logic             out_v;
  logic             cl3;
  logic             wb_v;
  logic             wb_rdy;
  logic [EW-1:0]    wb_dat;

  assign bank           = {bank_select_1_i, bank_select_0_i};
  assign mode_o         = mode_q;
  assign bank_open_o    = bank_open_q;
  assign self_refresh_o = sref_q;
  assign refresh_row_o  = ref_cnt_q;

  // Command decode from the strobes and clock enable
  always_comb begin
    cmd = sdram_pkg::C_INH;
    if (!cmd_i.cs_n && !sref_q) begin
      unique case ({cmd_i.ras_n, cmd_i.cas_n, cmd_i.we_n})
        3'b111: cmd = sdram_pkg::C_NOP;
        3'b011: cmd = sdram_pkg::C_ACT;
        3'b101: cmd = sdram_pkg::C_RD;
        3'b100: cmd = sdram_pkg::C_WR;
        3'b110: cmd = sdram_pkg::C_BST;
        3'b010: cmd = sdram_pkg::C_PRE;
        3'b001: cmd = cke_i ? sdram_pkg::C_REF : sdram_pkg::C_SREF;
        3'b000: cmd = sdram_pkg::C_LMR;
      endcase
      if (!cke_i && cmd != sdram_pkg::C_SREF) begin
        cmd = sdram_pkg::C_INH;
      end
    end
  end

  // Wrap block and length from the mode fields
  always_comb begin
    unique case (mode_q.burst_length_field)
      sdram_pkg::BL_2:    new_mask = sdram_pkg::MASK_2;
      sdram_pkg::BL_4:    new_mask = sdram_pkg::MASK_4;
      sdram_pkg::BL_8:    new_mask = sdram_pkg::MASK_8;
      sdram_pkg::BL_PAGE: new_mask = sdram_pkg::MASK_PAGE;
      default:            new_mask = sdram_pkg::MASK_1;
    endcase
    new_last = new_mask;
    if (cmd == sdram_pkg::C_WR && mode_q.write_burst_mode_bit) begin
      new_last = '0;
    end
  end

  // Column of the current beat: block bits kept, offset wraps
  assign cur_col = (bstart_q & ~bmask_q)
                 | ((binter_q ? (bstart_q ^ bk_q) : (bstart_q + bk_q)) & bmask_q);

  // Array access of this cycle: a new command or the running burst
  always_comb begin
    acc_v    = 1'b0;
    acc_wr   = 1'b0;
    acc_ap   = 1'b0;
    acc_end  = 1'b0;
    acc_bank = bbank_q;
    acc_col  = cur_col;
    if (cmd == sdram_pkg::C_RD || cmd == sdram_pkg::C_WR) begin
      acc_v    = 1'b1;
      acc_wr   = (cmd == sdram_pkg::C_WR);
      acc_ap   = addr_i[sdram_pkg::AP_BIT];
      acc_end  = (new_last == '0);
      acc_bank = bank;
      acc_col  = addr_i[9:0];
    end else if (bact_q && cmd != sdram_pkg::C_BST) begin
      acc_v   = 1'b1;
      acc_wr  = bwr_q;
      acc_ap  = bap_q;
      acc_end = (bk_q == blast_q);
    end
  end

  assign acc_idx = {acc_bank, open_row_q[acc_bank][ROW_KEEP-1:0], acc_col};

  // Mode register load
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_q <= sdram_pkg::MODE_RST;
    end else if (cmd == sdram_pkg::C_LMR) begin
      mode_q <= addr_i[sdram_pkg::MODE_W-1:0];
    end
  end

  // Burst sequencer
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bact_q   <= 1'b0;
      bwr_q    <= 1'b0;
      bap_q    <= 1'b0;
      binter_q <= 1'b0;
      bbank_q  <= '0;
      bstart_q <= '0;
      bmask_q  <= '0;
      bk_q     <= '0;
      blast_q  <= '0;
    end else if (cmd == sdram_pkg::C_RD || cmd == sdram_pkg::C_WR) begin
      bact_q   <= (new_last != '0);
      bwr_q    <= (cmd == sdram_pkg::C_WR);
      bap_q    <= addr_i[sdram_pkg::AP_BIT];
      binter_q <= mode_q.burst_type_bit
               && (mode_q.burst_length_field != sdram_pkg::BL_PAGE);
      bbank_q  <= bank;
      bstart_q <= addr_i[9:0];
      bmask_q  <= new_mask;
      bk_q     <= 10'h001;
      blast_q  <= new_last;
    end else if (cmd == sdram_pkg::C_BST) begin
      bact_q <= 1'b0;
    end else if (bact_q) begin
      bact_q <= (bk_q != blast_q);
      bk_q   <= bk_q + 10'h001;
    end
  end

  // Row state per bank
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bank_open_q <= '0;
      for (int b = 0; b < 4; b++) begin
        open_row_q[b] <= '0;
      end
    end else begin
      if (acc_v && acc_end && acc_ap) begin
        bank_open_q[acc_bank] <= 1'b0;
      end
      if (cmd == sdram_pkg::C_PRE) begin
        if (addr_i[sdram_pkg::AP_BIT]) begin
          bank_open_q <= '0;
        end else begin
          bank_open_q[bank] <= 1'b0;
        end
      end
      if (cmd == sdram_pkg::C_ACT) begin // Activate last, so an open wins
        bank_open_q[bank] <= 1'b1;
        open_row_q[bank]  <= addr_i;
      end
    end
  end

  // Refresh counter and self refresh state
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ref_cnt_q <= '0;
      sref_q    <= 1'b0;
    end else begin
      if (cmd == sdram_pkg::C_REF || cmd == sdram_pkg::C_SREF) begin
        ref_cnt_q <= ref_cnt_q + 13'h0001;
      end
      if (cmd == sdram_pkg::C_SREF) begin
        sref_q <= 1'b1;
      end else if (cke_i) begin
        sref_q <= 1'b0;
      end
    end
  end

  // Write beats enter the buffer with their byte mask at once
  assign wb_dat       = {acc_idx, byte_mask_i, dq_i};
  assign wbuf_ready_o = wb_rdy;

  logic             dr_v;
  logic             dr_rdy;
  logic [EW-1:0]    dr_dat;
  logic [IW-1:0]    dr_idx;
  logic [NB-1:0]    dr_msk;

  assign wb_v   = acc_v && acc_wr;
  assign dr_rdy = !(acc_v && !acc_wr);
  assign dr_idx = dr_dat[EW-1 -: IW];
  assign dr_msk = dr_dat[DQ_W +: NB];

  wr_fifo #(
    .WIDTH (EW),
    .DEPTH (WB_DEPTH)
  ) u_wbuf (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (wb_v),
    .in_ready_o  (wb_rdy),
    .in_data_i   (wb_dat),
    .out_valid_o (dr_v),
    .out_ready_i (dr_rdy),
    .out_data_o  (dr_dat)
  );

  // Array: reads have the port, buffered writes drain when it is free
  always_ff @(posedge core_clk_i) begin
    if (acc_v && !acc_wr) begin
      rd0_q <= arr_q[acc_idx];
    end
    rd1_q <= rd0_q;
    rd2_q <= rd1_q;
    if (dr_v && dr_rdy) begin
      for (int b = 0; b < NB; b++) begin
        if (!dr_msk[b]) begin
          arr_q[dr_idx][b*8 +: 8] <= dr_dat[b*8 +: 8];
        end
      end
    end
  end

  // Latency pipeline and two-clock read mask delay
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd0_v_q <= 1'b0;
      rd1_v_q <= 1'b0;
      rd2_v_q <= 1'b0;
      m1_q    <= '1;
      m2_q    <= '1;
    end else begin
      rd0_v_q <= acc_v && !acc_wr;
      rd1_v_q <= rd0_v_q;
      rd2_v_q <= rd1_v_q;
      m1_q    <= byte_mask_i;
      m2_q    <= m1_q;
    end
  end

  // Latency two drives after n+1, latency three after n+2
  assign cl3   = (mode_q.read_latency_field == sdram_pkg::CL_3);
  assign out_v = cl3 ? rd2_v_q : rd1_v_q;
  assign dq_o  = cl3 ? rd2_q : rd1_q;

  // Per-lane output enables
  for (genvar g = 0; g < NB; g++) begin : g_oe
    assign dq_oe_o[g] = out_v && !m2_q[g];
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  sequence rd_cl2_s;
    cmd == sdram_pkg::C_RD && mode_q.read_latency_field == sdram_pkg::CL_2;
  endsequence
  sequence rd_cl3_s;
    cmd == sdram_pkg::C_RD && cl3;
  endsequence

  mode_load_a:
    assert property (cmd == sdram_pkg::C_LMR |=> mode_q == $past(addr_i[11:0]))
    else $error("mode register not loaded");
  rd_lat_two_a:
    assert property (rd_cl2_s |-> ##1 rd0_v_q ##1 (out_v && dq_o == $past(rd0_q)))
    else $error("latency two data late");
  rd_lat_three_a:
    assert property (rd_cl3_s |-> ##1 rd0_v_q ##1 rd1_v_q ##1 out_v)
    else $error("latency three data late");
  blk_two_a:
    assert property (bact_q && bmask_q == 10'h001 |-> cur_col[9:1] == bstart_q[9:1])
    else $error("length two left block");
  blk_four_a:
    assert property (bact_q && bmask_q == 10'h003 |-> cur_col[9:2] == bstart_q[9:2])
    else $error("length four left block");
  blk_eight_a:
    assert property (bact_q && bmask_q == 10'h007 |-> cur_col[9:3] == bstart_q[9:3])
    else $error("length eight left block");
  seq_wrap_a:
    assert property (bact_q && !binter_q && bmask_q == 10'h003 && bstart_q[1:0] == 2'h3
                     && bk_q == 10'h001 |-> cur_col == {bstart_q[9:2], 2'h0})
    else $error("sequential burst did not wrap");
  page_burst_a:
    assert property (cmd == sdram_pkg::C_RD && mode_q.burst_length_field == 3'h7
                     |=> bact_q && !binter_q && blast_q == 10'h3ff)
    else $error("full page burst wrong");
  single_col_a:
    assert property ((cmd == sdram_pkg::C_RD || cmd == sdram_pkg::C_WR)
                     && mode_q.burst_length_field == 3'h0 |=> !bact_q)
    else $error("length one continued");
  ilv_order_a:
    assert property (bact_q && binter_q && bmask_q == 10'h007 && bstart_q[2:0] == 3'h1
                     && bk_q == 10'h002 |-> cur_col[2:0] == 3'h3)
    else $error("interleaved order wrong");
  wr_single_a:
    assert property (cmd == sdram_pkg::C_WR && mode_q.write_burst_mode_bit |=> !bact_q)
    else $error("write burst while single mode");
  pre_all_a:
    assert property (cmd == sdram_pkg::C_PRE && addr_i[10] |=> bank_open_o == 4'h0)
    else $error("precharge all left a bank open");
  sref_enter_a:
    assert property (cmd_i.cs_n == 1'b0 && cmd_i.ras_n == 1'b0 && cmd_i.cas_n == 1'b0
                     && cmd_i.we_n && !cke_i && !sref_q |=> self_refresh_o)
    else $error("self refresh not entered");
  ref_count_a:
    assert property (cmd == sdram_pkg::C_REF |=> refresh_row_o == $past(refresh_row_o) + 13'h0001)
    else $error("refresh row did not advance");
  mask_oe_a:
    assert property (##2 ((dq_oe_o & $past(byte_mask_i, 2)) == '0))
    else $error("masked lane driven");
  inhibit_a:
    assert property (cmd_i.cs_n && !bact_q |=> $stable(mode_q) && $stable(bank_open_q))
    else $error("inhibited command took effect");
endmodule

// ---- sdram_pkg.sv ----
package sdram_pkg;

  // Array geometry
  localparam int unsigned COL_W  = 10;
  localparam int unsigned ROW_W  = 13;
  localparam int unsigned MODE_W = 12;
  localparam int unsigned AP_BIT = 10;

  // Burst length codes
  localparam logic [2:0] BL_1    = 3'h0;
  localparam logic [2:0] BL_2    = 3'h1;
  localparam logic [2:0] BL_4    = 3'h2;
  localparam logic [2:0] BL_8    = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;

  // Column masks that set the wrap block of each burst length
  localparam logic [9:0] MASK_1    = 10'h000;
  localparam logic [9:0] MASK_2    = 10'h001;
  localparam logic [9:0] MASK_4    = 10'h003;
  localparam logic [9:0] MASK_8    = 10'h007;
  localparam logic [9:0] MASK_PAGE = 10'h3ff;

  // Read latency codes
  localparam logic [2:0] CL_2 = 3'h2;
  localparam logic [2:0] CL_3 = 3'h3;

  // Mode after reset: single beat, sequential, latency two
  localparam logic [11:0] MODE_RST = 12'h020;

  typedef struct packed {
    logic [1:0] rsvd;
    logic       write_burst_mode_bit;
    logic       op_mode_bit_high;
    logic       op_mode_bit_low;
    logic [2:0] read_latency_field;
    logic       burst_type_bit;
    logic [2:0] burst_length_field;
  } mode_t;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } cmd_pins_t;

  typedef enum {
    C_INH, C_NOP, C_ACT, C_RD, C_WR, C_BST, C_PRE, C_REF, C_SREF, C_LMR
  } cmd_t;

endpackage

// ---- sdram_ctrl_model.sv ----
`timescale 1ns/1ps
// Controller stand-in; every pin changes at the falling edge
module sdram_ctrl_model (
  input  wire logic            core_clk_i,
  output logic                 cke_o,
  output sdram_pkg::cmd_pins_t cmd_o,
  output logic      [1:0]      bank_o,
  output logic      [12:0]     addr_o,
  output logic      [7:0]      byte_mask_o,
  output logic      [63:0]     dq_o
);
  // Strobe codes {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] P_NOP = 4'h7;
  localparam logic [3:0] P_ACT = 4'h3;
  localparam logic [3:0] P_WR  = 4'h4;
  localparam logic [3:0] P_PRE = 4'h2;
  localparam logic [3:0] P_LMR = 4'h0;
  logic [63:0] wd;

  // Pins at time zero
  initial begin
    cke_o       = 1'b1;
    cmd_o       = P_NOP;
    bank_o      = 2'h0;
    addr_o      = 13'h0000;
    byte_mask_o = 8'h00;
    dq_o        = 64'h0;
    wd          = 64'h0;
  end

  // Data pattern tied to the column
  function automatic logic [63:0] pat(input logic [9:0] c);
    return {4{{6'h00, c} ^ 16'ha5c3}};
  endfunction

  // One command; data lines carry write data or keep toggling
  task automatic issue(input logic [3:0] c, input logic [1:0] ba, input logic [12:0] a);
    @(negedge core_clk_i);
    cmd_o  = c;
    bank_o = ba;
    addr_o = a;
    dq_o   = (c == P_WR) ? wd : ~dq_o;
  endtask

  // Idle cycle; don't-care lines move so stale values never match
  task automatic idle();
    @(negedge core_clk_i);
    cmd_o  = P_NOP;
    addr_o = ~addr_o;
    bank_o = ~bank_o;
    dq_o   = ~dq_o;
  endtask

  // Write burst from a block-aligned column, data with the command
  task automatic wr(input logic [1:0] ba, input logic [9:0] col, input int n,
                    input logic [63:0] x);
    wd = pat(col) ^ x;
    issue(P_WR, ba, {3'h0, col});
    for (int k = 1; k < n; k++) begin
      @(negedge core_clk_i);
      cmd_o = P_NOP;
      dq_o  = pat(col + 10'(k)) ^ x;
    end
  endtask

  // Mode load only with all banks idle, then wait and reopen bank 0
  task automatic set_mode(input sdram_pkg::mode_t m);
    sdram_pkg::mode_t v;
    v = m;
    v.op_mode_bit_high = 1'b0;
    v.op_mode_bit_low  = 1'b0;
    v.rsvd = 2'h0;
    issue(P_PRE, 2'h0, 13'h0400);
    idle();
    issue(P_LMR, 2'h0, {1'b0, v});
    repeat (3) idle();
    issue(P_ACT, 2'h0, 13'h0000);
    idle();
  endtask
endmodule

// ---- sdram_cmd_burst_tb.sv ----
`timescale 1ns/1ps
// Self-checking bench for command decode, mode and burst order
module sdram_cmd_burst_tb;
  logic                 core_clk_i = 1'b0;
  logic                 rst_i      = 1'b1;
  logic                 cke;
  sdram_pkg::cmd_pins_t cmd;
  logic [1:0]           bank;
  logic [12:0]          addr;
  logic [7:0]           bmask;
  logic [63:0]          dq_w;
  logic [63:0]          dq_r;
  logic [7:0]           dq_oe;
  sdram_pkg::mode_t     mode;
  logic [3:0]           bank_open;
  logic                 sref;
  logic [12:0]          rrow;
  logic                 wbuf_ready;
  int                   miscompares = 0;
  int                   n_tests     = 0;

  // 25 MHz clock
  always #20 core_clk_i = ~core_clk_i;

  sdram_ctrl_model i_sdram_ctrl_model (
    .core_clk_i (core_clk_i), .cke_o (cke), .cmd_o (cmd), .bank_o (bank),
    .addr_o (addr), .byte_mask_o (bmask), .dq_o (dq_w)
  );

  sdram_cmd_burst i_sdram_cmd_burst (
    .core_clk_i (core_clk_i), .rst_i (rst_i), .cke_i (cke), .cmd_i (cmd),
    .bank_select_0_i (bank[0]), .bank_select_1_i (bank[1]), .addr_i (addr),
    .byte_mask_i (bmask), .dq_i (dq_w), .dq_o (dq_r), .dq_oe_o (dq_oe),
    .mode_o (mode), .bank_open_o (bank_open), .self_refresh_o (sref),
    .refresh_row_o (rrow), .wbuf_ready_o (wbuf_ready)
  );

  // Compare and count
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  // Counts, verdict and end of run
  task automatic finish_test();
    $display("miscompares %0d n_tests %0d", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Mode word with operating mode and reserved bits zero
  function automatic sdram_pkg::mode_t mode_of(input logic w, input logic [2:0] cl,
                                               input logic bt, input logic [2:0] bl);
    sdram_pkg::mode_t m;
    m = '0;
    m.write_burst_mode_bit = w;
    m.read_latency_field = cl;
    m.burst_type_bit = bt;
    m.burst_length_field = bl;
    return m;
  endfunction

  // Read burst: enable timing, lane enables and column order per beat
  task automatic rd(input logic [9:0] st, input int len, input logic ilv, input int m,
                    input int nb, input logic ap, input logic [63:0] x);
    logic [9:0]  blk;
    logic [9:0]  c;
    logic [63:0] lm;
    blk = 10'(len - 1);
    for (int i = 0; i < 8; i++) lm[i*8 +: 8] = {8{~bmask[i]}};
    i_sdram_ctrl_model.issue(4'h5, 2'h0, {2'h0, ap, st});
    repeat (m - 1) i_sdram_ctrl_model.idle();
    check(64'(dq_oe), 64'h0);
    for (int k = 0; k < nb; k++) begin
      i_sdram_ctrl_model.idle();
      c = (st & ~blk) | ((ilv ? (st ^ 10'(k)) : (st + 10'(k))) & blk);
      check(64'(dq_oe), {56'h0, ~bmask});
      check(dq_r & lm, (i_sdram_ctrl_model.pat(c) ^ x) & lm);
    end
    if (nb == len) begin
      i_sdram_ctrl_model.idle();
      check(64'(dq_oe), 64'h0);
    end
  endtask

  // Values while reset is held
  task automatic t_reset();
    check(64'(mode), 64'h020);
    check(64'(bank_open), 64'h0);
    check(64'(dq_oe), 64'h0);
    check(64'(sref), 64'h0);
    check(64'(rrow), 64'h0);
    check(64'(wbuf_ready), 64'h1);
  endtask

  // Mode load, activate, inhibit, clock enable low, precharge
  task automatic t_cmds();
    sdram_pkg::mode_t mv;
    mv = mode_of(1'b0, sdram_pkg::CL_3, 1'b1, sdram_pkg::BL_4);
    i_sdram_ctrl_model.set_mode(mv);
    check(64'(mode), 64'(mv));
    i_sdram_ctrl_model.issue(4'h3, 2'h2, 13'h0000);
    i_sdram_ctrl_model.idle();
    check(64'(bank_open), 64'h5);
    i_sdram_ctrl_model.issue(4'hb, 2'h1, 13'h0000);
    i_sdram_ctrl_model.idle();
    check(64'(bank_open), 64'h5);
    i_sdram_ctrl_model.cke_o = 1'b0;
    i_sdram_ctrl_model.issue(4'h3, 2'h3, 13'h0000);
    i_sdram_ctrl_model.idle();
    i_sdram_ctrl_model.cke_o = 1'b1;
    check(64'(bank_open), 64'h5);
    i_sdram_ctrl_model.issue(4'h2, 2'h2, 13'h0000);
    i_sdram_ctrl_model.issue(4'h3, 2'h3, 13'h0000);
    i_sdram_ctrl_model.idle();
    check(64'(bank_open), 64'h9);
    i_sdram_ctrl_model.issue(4'h2, 2'h1, 13'h0400);
    i_sdram_ctrl_model.idle();
    check(64'(bank_open), 64'h0);
  endtask

  // Auto refresh, self refresh entry, refusal inside, exit
  task automatic t_refresh();
    logic [12:0] r0;
    r0 = rrow;
    i_sdram_ctrl_model.issue(4'h1, 2'h0, 13'h0000);
    i_sdram_ctrl_model.issue(4'h1, 2'h3, 13'h1fff);
    i_sdram_ctrl_model.idle();
    check(64'(rrow), 64'(r0 + 13'h2));
    check(64'(sref), 64'h0);
    i_sdram_ctrl_model.cke_o = 1'b0;
    i_sdram_ctrl_model.issue(4'h1, 2'h0, 13'h0000);
    i_sdram_ctrl_model.issue(4'h3, 2'h1, 13'h0000);
    i_sdram_ctrl_model.idle();
    check(64'(sref), 64'h1);
    check(64'(rrow), 64'(r0 + 13'h3));
    check(64'(bank_open), 64'h0);
    i_sdram_ctrl_model.cke_o = 1'b1;
    repeat (2) i_sdram_ctrl_model.idle();
    check(64'(sref), 64'h0);
  endtask

  // Burst orders for lengths one to eight, both types at four and eight, latency three, read mask
  task automatic t_bursts();
    i_sdram_ctrl_model.set_mode(mode_of(1'b0, sdram_pkg::CL_2, 1'b0, sdram_pkg::BL_8));
    i_sdram_ctrl_model.wr(2'h0, 10'd0, 8, 64'h0);
    i_sdram_ctrl_model.wr(2'h0, 10'd8, 8, 64'h0);
    repeat (40) i_sdram_ctrl_model.idle();
    rd(10'd5, 8, 1'b0, 2, 8, 1'b0, 64'h0);
    i_sdram_ctrl_model.set_mode(mode_of(1'b0, sdram_pkg::CL_2, 1'b1, sdram_pkg::BL_8));
    rd(10'd1, 8, 1'b1, 2, 8, 1'b0, 64'h0);
    i_sdram_ctrl_model.set_mode(mode_of(1'b0, sdram_pkg::CL_2, 1'b0, sdram_pkg::BL_4));
    rd(10'd11, 4, 1'b0, 2, 4, 1'b0, 64'h0);
    i_sdram_ctrl_model.set_mode(mode_of(1'b0, sdram_pkg::CL_3, 1'b1, sdram_pkg::BL_4));
    rd(10'd10, 4, 1'b1, 3, 4, 1'b0, 64'h0);
    i_sdram_ctrl_model.set_mode(mode_of(1'b0, sdram_pkg::CL_2, 1'b0, sdram_pkg::BL_2));
    rd(10'd3, 2, 1'b0, 2, 2, 1'b0, 64'h0);
    i_sdram_ctrl_model.set_mode(mode_of(1'b0, sdram_pkg::CL_2, 1'b1, sdram_pkg::BL_1));
    rd(10'd6, 1, 1'b0, 2, 1, 1'b0, 64'h0);
    i_sdram_ctrl_model.set_mode(mode_of(1'b0, sdram_pkg::CL_2, 1'b0, sdram_pkg::BL_8));
    i_sdram_ctrl_model.byte_mask_o = 8'h0f;
    repeat (2) i_sdram_ctrl_model.idle();
    rd(10'd12, 8, 1'b0, 2, 8, 1'b0, 64'h0);
    i_sdram_ctrl_model.byte_mask_o = 8'h00;
    repeat (2) i_sdram_ctrl_model.idle();
    rd(10'd0, 8, 1'b0, 2, 8, 1'b1, 64'h0);
    i_sdram_ctrl_model.idle();
    check(64'(bank_open), 64'h0);
  endtask

  // Single-location writes while reads still burst
  task automatic t_wbm();
    i_sdram_ctrl_model.set_mode(mode_of(1'b0, sdram_pkg::CL_2, 1'b0, sdram_pkg::BL_4));
    i_sdram_ctrl_model.wr(2'h0, 10'd32, 4, '1);
    i_sdram_ctrl_model.set_mode(mode_of(1'b1, sdram_pkg::CL_2, 1'b0, sdram_pkg::BL_4));
    i_sdram_ctrl_model.wr(2'h0, 10'd32, 4, 64'h0);
    repeat (40) i_sdram_ctrl_model.idle();
    rd(10'd33, 4, 1'b0, 2, 3, 1'b0, '1);
    i_sdram_ctrl_model.set_mode(mode_of(1'b1, sdram_pkg::CL_2, 1'b0, sdram_pkg::BL_1));
    rd(10'd32, 1, 1'b0, 2, 1, 1'b0, 64'h0);
  endtask

  // Full page wraps from column 1023 to 0, then burst terminate
  task automatic t_page();
    i_sdram_ctrl_model.set_mode(mode_of(1'b0, sdram_pkg::CL_2, 1'b0, sdram_pkg::BL_1));
    i_sdram_ctrl_model.wr(2'h0, 10'd1022, 1, 64'h0);
    i_sdram_ctrl_model.wr(2'h0, 10'd1023, 1, 64'h0);
    repeat (40) i_sdram_ctrl_model.idle();
    i_sdram_ctrl_model.set_mode(mode_of(1'b0, sdram_pkg::CL_2, 1'b0, sdram_pkg::BL_PAGE));
    rd(10'd1022, 1024, 1'b0, 2, 4, 1'b0, 64'h0);
    i_sdram_ctrl_model.issue(4'h6, 2'h0, 13'h0000);
    repeat (4) i_sdram_ctrl_model.idle();
    check(64'(dq_oe), 64'h0);
  endtask

  // Main sequence; reset held for three cycles
  initial begin
    repeat (3) @(negedge core_clk_i);
    t_reset();
    rst_i = 1'b0;
    t_cmds();
    t_refresh();
    t_bursts();
    t_wbm();
    t_page();
    finish_test();
  end

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #400us;
    miscompares++;
    finish_test();
  end
endmodule
